// [hdl/sfh_params.svh]
/*
 fault handler constants: register offsets, field positions, status
 codes, clock rate and timing. assumes a 25 MHz single clock.
*/
`ifndef SFH_PARAMS_SVH
`define SFH_PARAMS_SVH

`define SFH_CLK_HZ          25000000
// register byte offsets on the avalon slave
`define SFH_OFF_CTRL        4'h0
`define SFH_OFF_STATE       4'h4
`define SFH_OFF_IRQ_STAT    4'h8
`define SFH_OFF_IRQ_MASK    4'hc
// ctrl fields
`define SFH_CTRL_PDC_EN     0
`define SFH_CTRL_TRIG       1
`define SFH_CTRL_LOCK       2
`define SFH_CTRL_SW_EN      3
// interrupt / status event bits
`define SFH_EV_RST          0
`define SFH_EV_FAC          1
`define SFH_EV_USR          2
`define SFH_EV_REG          3
`define SFH_EV_UV           4
`define SFH_EV_W            5
// periodic-mode status codes
`define SFH_CODE_OK         4'h0
`define SFH_CODE_FAC        4'h2
`define SFH_CODE_USR        4'h3
`define SFH_CODE_REG        4'h4
`define SFH_CODE_ST         4'h8
// timing, in microseconds and in clock cycles
`define SFH_BS_OFF_US       10
`define SFH_CAP_RETRY_US    1000
`define SFH_BS_OFF_CYC      ((`SFH_BS_OFF_US * 25) > 1 ? (`SFH_BS_OFF_US * 25) : 1)
`define SFH_CAP_RETRY_CYC   (`SFH_CAP_RETRY_US * 25)

`endif

// [hdl/sfh_pkg.sv]
/*
 types for the sensor fault handler. assumes sfh_params.svh alongside.
*/
package sfh_pkg;
    typedef enum logic [1:0] {
        RUN,
        HOLD_UV,
        HOLD_CAP
    } state_type;
endpackage

// [hdl/sfh_sync3.sv]
/*
 three-flop input synchroniser with agreement filter.
 assumes async single-bit inputs and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfh_sync3 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end
endmodule
`default_nettype wire

// [hdl/sfh_top.sv]
/*
 sensor fault and exception handler: reset holding on supply faults,
 bus switch release, capacitor retry, status code and self-check gating.
 assumes analog fault inputs are asynchronous and an avalon-mm master.
*/
// What this block does
// - regulator undervoltage holds reset, no answers
// - reset fault turns bus switch off quickly
// - capacitor fault retries reset each period
// - factory memory crc gives code 0010
// - locked user memory crc gives 0011
// - register crc in periodic mode gives 0100
// - init trigger enables self-check, clears flag
// - trigger during periodic mode is ignored
// - periodic without self-check reports code 1000
// - init before self-check answers normally
// - power-on sets unfinished flag, code 1000
// - bus or buffer undervolt flags, no current
`timescale 1ns/1ps
`default_nettype none
`include "sfh_params.svh"
module sfh_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        analog_regulator_uv,
    input  wire logic        cap_test_fail,
    input  wire logic        bus_input_uv,
    input  wire logic        buffer_uv,
    input  wire logic        factory_crc_err,
    input  wire logic        user_crc_err,
    input  wire logic        reg_crc_err,
    output var  logic        device_reset_hold,
    output logic             respond_enable,
    output logic             response_current_enable,
    output var  logic        downstream_bus_switch,
    output var  logic        self_check_enable,
    output var  logic        self_check_unfinished,
    output var  logic        accel_self_check_data,
    output var  logic        periodic_error_response,
    output var  logic [3:0]  periodic_status,
    output var  logic        bus_input_undervolt_flag,
    output var  logic        buffer_undervolt_flag,
    output logic             irq
);
    import sfh_pkg::*;

    localparam int BS_OFF_CYC = `SFH_BS_OFF_CYC;
    localparam int CAP_CYC    = `SFH_CAP_RETRY_CYC;

    logic       reg_uv_s;
    logic       cap_s;
    logic       busi_s;
    logic       buf_s;
    logic       fac_s;
    logic       usr_s;
    logic       rcrc_s;
    state_type  state_q;
    logic [14:0] cap_cnt_q;
    logic [8:0]  off_cnt_q;
    logic       pdc_en_q;
    logic       lock_q;
    logic       sw_req_q;
    logic       trig;
    logic [5:0] stat_q;
    logic [5:0] mask_q;
    logic [5:0] ev;
    logic       hold;
    logic       hold_q;
    logic [3:0] code_d;
    logic       rd_pend_q;

    sfh_sync3 u_s0 (.clk(clk), .rst(rst), .din(analog_regulator_uv),
                    .dout(reg_uv_s));
    sfh_sync3 u_s1 (.clk(clk), .rst(rst), .din(cap_test_fail),
                    .dout(cap_s));
    sfh_sync3 u_s2 (.clk(clk), .rst(rst), .din(bus_input_uv),
                    .dout(busi_s));
    sfh_sync3 u_s3 (.clk(clk), .rst(rst), .din(buffer_uv),
                    .dout(buf_s));
    sfh_sync3 u_s4 (.clk(clk), .rst(rst), .din(factory_crc_err),
                    .dout(fac_s));
    sfh_sync3 u_s5 (.clk(clk), .rst(rst), .din(user_crc_err),
                    .dout(usr_s));
    sfh_sync3 u_s6 (.clk(clk), .rst(rst), .din(reg_crc_err),
                    .dout(rcrc_s));

    // fault state machine; undervoltage outranks the capacitor test
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= RUN;
            cap_cnt_q <= 15'h0000;
        end else begin
            unique case (state_q)
                RUN: begin
                    cap_cnt_q <= 15'h0000;
                    if (reg_uv_s) begin
                        state_q <= HOLD_UV;
                    end else if (cap_s) begin
                        state_q <= HOLD_CAP;
                    end
                end
                HOLD_UV: begin
                    if (!reg_uv_s) begin
                        state_q <= RUN;
                    end
                end
                HOLD_CAP: begin
                    // fault looked at once per period; reset held meanwhile
                    if (reg_uv_s) begin
                        state_q <= HOLD_UV;
                    end else if (cap_cnt_q == 15'(CAP_CYC - 1)) begin
                        cap_cnt_q <= 15'h0000;
                        if (!cap_s) begin
                            state_q <= RUN;
                        end
                    end else begin
                        cap_cnt_q <= cap_cnt_q + 15'h0001;
                    end
                end
            endcase
        end
    end

    assign hold = (state_q != RUN);

    always_ff @(posedge clk) begin
        if (rst) begin
            device_reset_hold <= 1'b0;
            hold_q            <= 1'b0;
        end else begin
            device_reset_hold <= hold;
            hold_q            <= hold;
        end
    end

    // no answers while held; undervolts only silence the current
    assign respond_enable = !hold;
    assign response_current_enable = !hold && !busi_s && !buf_s;

    // switch released well inside the off time (one cycle after hold)
    always_ff @(posedge clk) begin
        if (rst) begin
            downstream_bus_switch <= 1'b0;
            off_cnt_q             <= 9'h000;
        end else if (hold) begin
            downstream_bus_switch <= 1'b0;
            // times the hold so the off deadline can be checked
            if (off_cnt_q != 9'(BS_OFF_CYC)) begin
                off_cnt_q <= off_cnt_q + 9'h001;
            end
        end else begin
            downstream_bus_switch <= sw_req_q;
            off_cnt_q             <= 9'h000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_input_undervolt_flag <= 1'b0;
            buffer_undervolt_flag    <= 1'b0;
        end else begin
            bus_input_undervolt_flag <= busi_s;
            buffer_undervolt_flag    <= buf_s;
        end
    end

    // control register; a device reset wipes configuration too
    assign trig = avs_write && !avs_waitrequest
                  && avs_address == `SFH_OFF_CTRL
                  && avs_writedata[`SFH_CTRL_TRIG];

    always_ff @(posedge clk) begin
        if (rst || hold) begin
            pdc_en_q <= 1'b0;
            lock_q   <= 1'b0;
            sw_req_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == `SFH_OFF_CTRL) begin
            pdc_en_q <= avs_writedata[`SFH_CTRL_PDC_EN];
            lock_q   <= avs_writedata[`SFH_CTRL_LOCK];
            sw_req_q <= avs_writedata[`SFH_CTRL_SW_EN];
        end
    end

    // self-check is accepted only in initialization
    always_ff @(posedge clk) begin
        if (rst || hold) begin
            self_check_enable     <= 1'b0;
            self_check_unfinished <= 1'b1;
            accel_self_check_data <= 1'b0;
        end else if (trig && !pdc_en_q) begin
            self_check_enable     <= 1'b1;
            self_check_unfinished <= 1'b0;
            accel_self_check_data <= 1'b1;
        end
        // trigger with periodic mode on leaves all unchanged
    end

    // single code, fixed priority; self-check code shows at power-on
    always_comb begin
        if (fac_s) begin
            code_d = `SFH_CODE_FAC;
        end else if (usr_s && lock_q) begin
            code_d = `SFH_CODE_USR;
        end else if (rcrc_s && pdc_en_q) begin
            code_d = `SFH_CODE_REG;
        end else if (self_check_unfinished) begin
            code_d = `SFH_CODE_ST;
        end else begin
            code_d = `SFH_CODE_OK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            periodic_status         <= `SFH_CODE_ST;
            periodic_error_response <= 1'b0;
        end else begin
            periodic_status <= code_d;
            // accel stays normal when only self-check is unfinished
            periodic_error_response <= code_d == `SFH_CODE_FAC
                || code_d == `SFH_CODE_USR
                || code_d == `SFH_CODE_REG;
        end
    end

    // interrupt events; set beats a write-one clear
    assign ev = {1'b0, busi_s | buf_s, rcrc_s & pdc_en_q,
                 usr_s & lock_q, fac_s, hold & !hold_q};

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= 6'h00;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == `SFH_OFF_IRQ_STAT) begin
            stat_q <= (stat_q & ~avs_writedata[5:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= 6'h00;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == `SFH_OFF_IRQ_MASK) begin
            mask_q <= avs_writedata[5:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    // reads take one wait cycle, writes none
    assign avs_waitrequest = avs_read && !rd_pend_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pend_q    <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_pend_q <= avs_read && !rd_pend_q;
            if (avs_read && !rd_pend_q) begin
                unique case (avs_address)
                    `SFH_OFF_CTRL:
                        avs_readdata <= {28'h0000000, sw_req_q, lock_q,
                                         1'b0, pdc_en_q};
                    `SFH_OFF_STATE:
                        avs_readdata <= {20'h00000, periodic_status,
                                         2'h0, bus_input_undervolt_flag,
                                         buffer_undervolt_flag,
                                         self_check_enable,
                                         self_check_unfinished,
                                         downstream_bus_switch,
                                         device_reset_hold};
                    `SFH_OFF_IRQ_STAT:
                        avs_readdata <= {26'h0, stat_q};
                    `SFH_OFF_IRQ_MASK:
                        avs_readdata <= {26'h0, mask_q};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    a_uv_holds: assert property (@(posedge clk) disable iff (rst)
        reg_uv_s |=> hold)
        else $error("undervolt did not hold reset");
    a_no_answer: assert property (@(posedge clk) disable iff (rst)
        reg_uv_s |=> !respond_enable)
        else $error("answered while held");
    a_switch_off: assert property (@(posedge clk) disable iff (rst)
        hold |-> ##[1:2] !downstream_bus_switch)
        else $error("bus switch not released");
    a_switch_late: assert property (@(posedge clk) disable iff (rst)
        off_cnt_q == 9'(BS_OFF_CYC) |-> !downstream_bus_switch)
        else $error("bus switch past its off time");
    a_cap_retry: assert property (@(posedge clk) disable iff (rst)
        (state_q == HOLD_CAP && !reg_uv_s
         && cap_cnt_q != 15'(CAP_CYC - 1))
        |=> state_q == HOLD_CAP)
        else $error("capacitor hold left early");
    a_fac_code: assert property (@(posedge clk) disable iff (rst)
        fac_s |=> periodic_status == 4'h2 && periodic_error_response)
        else $error("factory code wrong");
    a_usr_code: assert property (@(posedge clk) disable iff (rst)
        (!fac_s && usr_s && lock_q) |=> periodic_status == 4'h3)
        else $error("user code wrong");
    a_reg_code: assert property (@(posedge clk) disable iff (rst)
        (!fac_s && !(usr_s && lock_q) && rcrc_s && pdc_en_q)
        |=> periodic_status == 4'h4)
        else $error("register code wrong");
    a_trig_ignored: assert property (@(posedge clk) disable iff (rst)
        (trig && pdc_en_q && self_check_unfinished && !hold)
        |=> self_check_unfinished)
        else $error("trigger not ignored");
    a_trig_taken: assert property (@(posedge clk) disable iff (rst)
        (trig && !pdc_en_q && !hold) |=> !self_check_unfinished
        && self_check_enable)
        else $error("trigger not taken");
    a_st_code: assert property (@(posedge clk) disable iff (rst)
        (!fac_s && !usr_s && !rcrc_s && self_check_unfinished)
        |=> periodic_status == 4'h8 && !periodic_error_response)
        else $error("self-check code wrong");
    a_uv_current: assert property (@(posedge clk) disable iff (rst)
        busi_s |-> !response_current_enable ##1 bus_input_undervolt_flag)
        else $error("current with undervolt");

    c_cap_cycle: cover property (@(posedge clk) disable iff (rst)
        state_q == HOLD_CAP ##1 state_q == RUN);
    c_uv_hold: cover property (@(posedge clk) disable iff (rst)
        state_q == HOLD_UV);
    c_selfcheck: cover property (@(posedge clk) disable iff (rst)
        trig && !pdc_en_q);
    c_irq: cover property (@(posedge clk) disable iff (rst) irq);
endmodule
`default_nettype wire

// [dv/sfh_master_model.sv]
/*
 bus master model: drives the avalon register port of the fault handler
 and configures the device again after every release of reset holding.
 assumes one clock and the register map of sfh_params.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfh_params.svh"
module sfh_master_model (
    input  wire logic        clk,
    input  wire logic        device_reset_hold,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output var  logic [3:0]  avs_address,
    output var  logic        avs_read,
    output var  logic        avs_write,
    output var  logic [31:0] avs_writedata
);
    logic [31:0] config_q = 32'h0;
    logic        stale_q = 1'b0;
    logic        hold_q = 1'b0;
    int          gap = 0;
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // a released hold leaves the device unconfigured
    always @(posedge clk) begin
        if (hold_q && !device_reset_hold) stale_q <= 1'b1;
        hold_q <= device_reset_hold;
    end
    // slow or prompt: gap idles before the request
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        repeat (gap + 1) @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // no cycle count assumed; the bench watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (w && a == `SFH_OFF_CTRL && !device_reset_hold) config_q = d & 32'hd;
    endtask
    task automatic reinit();
        logic [31:0] q;
        // stale flag lands one edge after the hold drops
        @(posedge clk);
        if (stale_q) begin
            stale_q = 1'b0;
            xfer(1'b1, `SFH_OFF_CTRL, config_q, q);
        end
    endtask
endmodule
`default_nettype wire

// [dv/sfh_tb_top.sv]
/*
 testbench of the fault handler: drives fault inputs, checks status ports
 and register views. assumes sfh_master_model carries all bus traffic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfh_params.svh"
module sensor_fault_status_handler_tb_top;
    import sfh_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        analog_regulator_uv = 1'b0;
    logic        cap_test_fail = 1'b0;
    logic        bus_input_uv = 1'b0;
    logic        buffer_uv = 1'b0;
    logic        factory_crc_err = 1'b0;
    logic        user_crc_err = 1'b0;
    logic        reg_crc_err = 1'b0;
    logic [3:0]  avs_address, periodic_status;
    logic [31:0] avs_readdata, avs_writedata;
    logic        avs_read, avs_write, avs_waitrequest, irq;
    logic        device_reset_hold, respond_enable, response_current_enable;
    logic        downstream_bus_switch, self_check_enable;
    logic        self_check_unfinished, accel_self_check_data;
    logic        periodic_error_response, bus_input_undervolt_flag;
    logic        buffer_undervolt_flag;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;
    always #20 clk = ~clk;
    sfh_top sfh_top_i (.clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .analog_regulator_uv,
        .cap_test_fail, .bus_input_uv, .buffer_uv, .factory_crc_err,
        .user_crc_err, .reg_crc_err, .device_reset_hold, .respond_enable,
        .response_current_enable, .downstream_bus_switch, .self_check_enable,
        .self_check_unfinished, .accel_self_check_data,
        .periodic_error_response, .periodic_status, .bus_input_undervolt_flag,
        .buffer_undervolt_flag, .irq);
    sfh_master_model sfh_master_model_i (.clk, .device_reset_hold,
        .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
        .avs_writedata);
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        sfh_master_model_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        sfh_master_model_i.xfer(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        tick(12);
        rst <= 1'b0;
        tick(1);
    endtask
    // wait bounded for the hold level; synchroniser takes a few edges
    task automatic wait_hold(input logic v, input int lim);
        n = 0;
        while (device_reset_hold !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    initial begin
        tick(95000);
        fail_count++;
        wrap_up();
    end
    initial begin
        do_reset();
        check("code", periodic_status, 4'h8);
        check("unfin", self_check_unfinished, 1'b1);
        rdc("state", `SFH_OFF_STATE, 32'h804);
        wr(4'h2, 32'hffffffff);
        rdc("unmapped", 4'h2, 32'h0);
        wr(`SFH_OFF_CTRL, 32'h8);
        rdc("ctrl", `SFH_OFF_CTRL, 32'h8);
        check("answer", respond_enable, 1'b1);
        check("switch", downstream_bus_switch, 1'b1);
        wr(`SFH_OFF_CTRL, 32'ha);
        tick(2);
        check("st_en", self_check_enable, 1'b1);
        check("st_unf", self_check_unfinished, 1'b0);
        check("st_data", accel_self_check_data, 1'b1);
        check("st_code", periodic_status, `SFH_CODE_OK);
        rdc("trig_rd", `SFH_OFF_CTRL, 32'h8);
        do_reset();
        wr(`SFH_OFF_CTRL, 32'h1);
        wr(`SFH_OFF_CTRL, 32'h3);
        tick(2);
        check("ign_en", self_check_enable, 1'b0);
        check("ign_data", accel_self_check_data, 1'b0);
        check("pd_unf", self_check_unfinished, 1'b1);
        check("pd_code", periodic_status, `SFH_CODE_ST);
        check("pd_err", periodic_error_response, 1'b0);
        wr(`SFH_OFF_IRQ_MASK, 32'h3f);
        wr(`SFH_OFF_CTRL, 32'h0);
        reg_crc_err <= 1'b1;
        tick(8);
        check("reg_off", periodic_status, `SFH_CODE_ST);
        wr(`SFH_OFF_CTRL, 32'h1);
        tick(2);
        check("reg_code", periodic_status, `SFH_CODE_REG);
        check("reg_err", periodic_error_response, 1'b1);
        user_crc_err <= 1'b1;
        tick(8);
        check("unlocked", periodic_status, `SFH_CODE_REG);
        wr(`SFH_OFF_CTRL, 32'h5);
        tick(2);
        check("usr_code", periodic_status, `SFH_CODE_USR);
        factory_crc_err <= 1'b1;
        tick(8);
        check("fac_code", periodic_status, `SFH_CODE_FAC);
        check("fac_err", periodic_error_response, 1'b1);
        rdc("irq_st", `SFH_OFF_IRQ_STAT, 32'he);
        check("irq", irq, 1'b1);
        factory_crc_err <= 1'b0;
        user_crc_err <= 1'b0;
        reg_crc_err <= 1'b0;
        tick(8);
        check("clr_code", periodic_status, `SFH_CODE_ST);
        wr(`SFH_OFF_IRQ_STAT, 32'he);
        rdc("w1c", `SFH_OFF_IRQ_STAT, 32'h0);
        wr(`SFH_OFF_IRQ_MASK, 32'h0);
        reg_crc_err <= 1'b1;
        tick(8);
        check("masked", irq, 1'b0);
        wr(`SFH_OFF_IRQ_MASK, 32'h8);
        tick(1);
        check("unmask", irq, 1'b1);
        reg_crc_err <= 1'b0;
        tick(8);
        wr(`SFH_OFF_IRQ_STAT, 32'h3f);
        tick(1);
        check("irq_clr", irq, 1'b0);
        bus_input_uv <= 1'b1;
        tick(8);
        check("busf", bus_input_undervolt_flag, 1'b1);
        check("cur", response_current_enable, 1'b0);
        check("cmd", respond_enable, 1'b1);
        rdc("st_bus", `SFH_OFF_STATE, 32'h824);
        bus_input_uv <= 1'b0;
        buffer_uv <= 1'b1;
        tick(8);
        check("buff", buffer_undervolt_flag, 1'b1);
        rdc("st_buf", `SFH_OFF_STATE, 32'h814);
        buffer_uv <= 1'b0;
        tick(8);
        check("cur_on", response_current_enable, 1'b1);
        wr(`SFH_OFF_CTRL, 32'h8);
        analog_regulator_uv <= 1'b1;
        wait_hold(1'b1, 16);
        check("uv_hold", device_reset_hold, 1'b1);
        n = 0;
        while (downstream_bus_switch !== 1'b0 && n < `SFH_BS_OFF_CYC) begin
            tick(1);
            n++;
        end
        check("uv_sw", downstream_bus_switch, 1'b0);
        check("uv_ans", respond_enable, 1'b0);
        wr(`SFH_OFF_CTRL, 32'h1);
        rdc("uv_ctrl", `SFH_OFF_CTRL, 32'h0);
        rdc("uv_irq", `SFH_OFF_IRQ_STAT, 32'h11);
        analog_regulator_uv <= 1'b0;
        wait_hold(1'b0, 16);
        check("uv_rel", device_reset_hold, 1'b0);
        sfh_master_model_i.gap = 3;
        sfh_master_model_i.reinit();
        tick(2);
        check("re_sw", downstream_bus_switch, 1'b1);
        check("re_unf", self_check_unfinished, 1'b1);
        cap_test_fail <= 1'b1;
        wait_hold(1'b1, 16);
        tick(2);
        check("cap_sw", downstream_bus_switch, 1'b0);
        n = 0;
        for (int i = 0; i < 30000; i++) begin
            tick(1);
            if (device_reset_hold !== 1'b1 || respond_enable !== 1'b0) n++;
        end
        check("cap_gaps", n, 0);
        cap_test_fail <= 1'b0;
        wait_hold(1'b0, `SFH_CAP_RETRY_CYC + 100);
        check("cap_rel", device_reset_hold, 1'b0);
        sfh_master_model_i.reinit();
        tick(2);
        check("cap_re", downstream_bus_switch, 1'b1);
        check("cap_ans", respond_enable, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
